// >>> tltx_defs.svh
// Purpose: Constants for the timing line transmit port control
// Assumes: Included by bare name; definitions only
// Notes:   Field widths and encodings of the control bits
`ifndef TLTX_DEFS_SVH
`define TLTX_DEFS_SVH
`define TLTX_SEL_W        4
`define TLTX_SEL_TIN      4'h0
`define TLTX_SEL_OC8      4'h8
`define TLTX_SEL_OC9      4'h9
`define TLTX_OC_W         9
`define TLTX_MODE_W       2
`define TLTX_SRC_FS       1'h0
`define TLTX_SRC_MFS      1'h1
`define TLTX_SYNC_STAGES  2
`define TLTX_RST_BIT      1'h0
`define TLTX_RST_NRZ      1'h1
`endif

// >>> tltx_pkg.sv
// Purpose: Types for the timing line transmit port control
// Assumes: tltx_defs.svh holds the numbers
// Notes:   Per-transceiver configuration and line outputs
`include "tltx_defs.svh"
package tltx_pkg;
   typedef struct packed {
      logic [`TLTX_SEL_W-1:0]  clock_source_select_field;
      logic [`TLTX_MODE_W-1:0] transmit_mode_field;
      logic                    clock_out_enable_bit;
      logic                    clock_polarity_bit;
      logic                    multipurpose_out_enable_bit;
      logic                    multipurpose_out_source_field;
      logic                    line_driver_on_bit;
      logic                    transmitter_powerdown_bit;
   } tltx_cfg_t;

   typedef struct packed {
      logic pos;
      logic neg;
      logic oe;
   } tltx_line_t;
endpackage

// >>> tltx_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: One clock domain, synchronous active-high reset
// Notes:   First stage read only by the second stage
`timescale 1ns/1ps
`include "tltx_defs.svh"
module tltx_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule

// >>> tltx_port.sv
// Purpose: Transmit-side pin control of one timing line transceiver
// Assumes: Selected transmit clock is sampled by clk_i; instantiate twice
// Notes:   Line encoder and receive path live elsewhere
`timescale 1ns/1ps
`include "tltx_defs.svh"
module tltx_port (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire tltx_pkg::tltx_cfg_t     cfg_i,
   input  wire logic [`TLTX_OC_W-1:0]   output_clocks_i,
   input  wire logic                    tx_multipurpose_in_i,
   input  wire logic                    tx_serial_data_in_i,
   input  wire logic                    line_hiz_pin_i,
   input  wire logic                    frame_sync_i,
   input  wire logic                    multiframe_sync_i,
   input  wire logic                    overhead_from_pin_i,
   input  wire logic                    overhead_slot_i,
   input  wire logic                    overhead_gen_i,
   input  wire logic                    sync_from_pin_i,
   input  wire logic                    line_pos_i,
   input  wire logic                    line_neg_i,
   output logic                         tx_clock_out_o,
   output logic                         tx_clock_out_oe_o,
   output logic                         tx_multipurpose_out_o,
   output logic                         tx_multipurpose_out_oe_o,
   output logic                         nrz_data_o,
   output logic                         nrz_valid_o,
   output logic                         pin_sync_o,
   output tltx_pkg::tltx_line_t         line_o
);
   // Pins and the output clocks are foreign to clk_i
   logic [`TLTX_OC_W+2:0] pins_s;
   logic [`TLTX_OC_W-1:0] oc_s;
   logic                  hiz_s;
   logic                  tin_s;
   logic                  ser_s;
   logic                  mux_clk;
   logic                  clk_prev_q;
   logic                  sample_edge;
   logic                  ds1e1_mode;
   logic                  ser_take;
   logic                  nrz_bit;
   logic                  mp_src;
   logic                  line_en;
   logic                  clk_raw;

   // Every clock pin is synchronised before the mux reads it
   tltx_sync #(.W(`TLTX_OC_W + 3)) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     ({output_clocks_i, line_hiz_pin_i, tx_multipurpose_in_i,
                 tx_serial_data_in_i}),
      .q_o     (pins_s)
   );
   assign oc_s  = pins_s[`TLTX_OC_W+2:3];
   assign hiz_s = pins_s[2];
   assign tin_s = pins_s[1];
   assign ser_s = pins_s[0];

   // 0000 takes the input pin, 1..7 and 9 the output clocks
   assign clk_raw =
      (cfg_i.clock_source_select_field == `TLTX_SEL_TIN) ?
         tin_s :
      ((cfg_i.clock_source_select_field <= `TLTX_SEL_OC9) &&
       (cfg_i.clock_source_select_field != `TLTX_SEL_OC8)) ?
         oc_s[cfg_i.clock_source_select_field - 4'h1] :
         1'h0;
   // Select changes may glitch the clock; one extra sample at most
   assign mux_clk = clk_raw;

   // rising when polarity clear, falling when set
   assign sample_edge = cfg_i.clock_polarity_bit ?
                        (clk_prev_q & ~mux_clk) :
                        (~clk_prev_q & mux_clk);
   assign ds1e1_mode = ~cfg_i.transmit_mode_field[1];
   // overhead slots use the pin only when so configured
   assign ser_take = ~overhead_slot_i | overhead_from_pin_i;
   // outside DS1/E1 the pin is ignored; idle data is ones
   assign nrz_bit = ds1e1_mode ?
                    (ser_take ? ser_s : overhead_gen_i) :
                    1'h1;
   assign mp_src = (cfg_i.multipurpose_out_source_field == `TLTX_SRC_MFS) ?
                   multiframe_sync_i : frame_sync_i;
   assign line_en = ~hiz_s & cfg_i.line_driver_on_bit &
                    ~cfg_i.transmitter_powerdown_bit;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         clk_prev_q <= `TLTX_RST_BIT;
      end else begin
         clk_prev_q <= mux_clk;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_clock_out_o    <= `TLTX_RST_BIT;
         tx_clock_out_oe_o <= `TLTX_RST_BIT;
      end else begin
         tx_clock_out_o    <= mux_clk;
         tx_clock_out_oe_o <= cfg_i.clock_out_enable_bit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_multipurpose_out_o    <= `TLTX_RST_BIT;
         tx_multipurpose_out_oe_o <= `TLTX_RST_BIT;
      end else begin
         tx_multipurpose_out_o    <= mp_src;
         tx_multipurpose_out_oe_o <= cfg_i.multipurpose_out_enable_bit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         nrz_data_o  <= `TLTX_RST_NRZ;
         nrz_valid_o <= `TLTX_RST_BIT;
         pin_sync_o  <= `TLTX_RST_BIT;
      end else begin
         nrz_valid_o <= sample_edge;
         if (sample_edge) begin
            nrz_data_o <= nrz_bit;
            // sync from pin only in DS1/E1 and when chosen
            pin_sync_o <= tin_s & ds1e1_mode & sync_from_pin_i;
         end
      end
   end

   // Tristate wins over data: enable and data drop together
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         line_o <= '0;
      end else begin
         line_o.oe  <= line_en;
         line_o.pos <= line_en & line_pos_i;
         line_o.neg <= line_en & line_neg_i;
      end
   end

   // Assertions: line outputs
   line_hiz_pd_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      cfg_i.transmitter_powerdown_bit |=> !line_o.oe)
      else $error("line driven while powered down");
   line_drv_off_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !cfg_i.line_driver_on_bit |=> !line_o.oe)
      else $error("line driven with driver bit clear");
   line_hiz_pin_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      hiz_s |=> !line_o.oe)
      else $error("line driven with hiz pin high");
   line_on_ok_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (!hiz_s && cfg_i.line_driver_on_bit &&
       !cfg_i.transmitter_powerdown_bit) |=> line_o.oe)
      else $error("line not driven when enabled");
   line_data_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      line_en |=> (line_o.pos == $past(line_pos_i)) &&
                  (line_o.neg == $past(line_neg_i)))
      else $error("line data not passed through");
   line_quiet_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !line_o.oe |-> !line_o.pos && !line_o.neg)
      else $error("line data while tristated");

   // Clock output
   clk_out_en_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ##1 tx_clock_out_oe_o == $past(cfg_i.clock_out_enable_bit))
      else $error("clock enable mismatch");
   clk_out_mux_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ##1 tx_clock_out_o == $past(mux_clk))
      else $error("clock out not mux");
   tin_route_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      cfg_i.clock_source_select_field == `TLTX_SEL_TIN |=>
         tx_clock_out_o == $past(tin_s))
      else $error("clock select 0000 not input pin");
   clk_stop_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (cfg_i.clock_source_select_field == `TLTX_SEL_OC8 ||
       cfg_i.clock_source_select_field > `TLTX_SEL_OC9) |=> !tx_clock_out_o)
      else $error("unused clock select not stopped");

   // Sync output
   mp_en_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ##1 tx_multipurpose_out_oe_o ==
         $past(cfg_i.multipurpose_out_enable_bit))
      else $error("sync output enable mismatch");
   mp_source_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      cfg_i.multipurpose_out_source_field |=>
         tx_multipurpose_out_o == $past(multiframe_sync_i))
      else $error("multipurpose source wrong");
   mp_frame_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !cfg_i.multipurpose_out_source_field |=>
         tx_multipurpose_out_o == $past(frame_sync_i))
      else $error("frame sync not routed");

   // Sampling of serial data and sync
   sample_rise_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (!cfg_i.clock_polarity_bit && $rose(mux_clk)) |=> nrz_valid_o)
      else $error("no sample on rising edge");
   sample_fall_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (cfg_i.clock_polarity_bit && $fell(mux_clk)) |=> nrz_valid_o)
      else $error("no sample on falling edge");
   sample_idle_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !$changed(mux_clk) |=> !nrz_valid_o)
      else $error("sample without clock edge");
   nrz_take_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (sample_edge && ds1e1_mode && ser_take) |=> nrz_data_o == $past(ser_s))
      else $error("serial data not taken");
   oh_gen_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (sample_edge && ds1e1_mode && !ser_take) |=>
         nrz_data_o == $past(overhead_gen_i))
      else $error("generated overhead not used");
   nrz_ignore_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (sample_edge && !ds1e1_mode) |=> nrz_data_o)
      else $error("serial input used outside DS1/E1");
   sync_mode_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (sample_edge && !ds1e1_mode) |=> !pin_sync_o)
      else $error("pin sync taken outside DS1/E1");
endmodule

// >>> tltx_far_end.sv
// Purpose: Far-end framing logic: link clock and serial data
// Assumes: 125 ns link clock that stands still between bursts
// Notes:   Data moves on the edge that is not sampled
`timescale 1ns/1ps
module tltx_far_end (
   input  wire logic pol_i,
   input  wire logic tie_i,
   output logic      lclk_o,
   output logic      ser_o
);
   initial begin
      lclk_o = 1'h0;
      ser_o  = 1'h1;
   end
   task automatic burst(input logic [7:0] pat);
      for (int i = 0; i < 8; i++) begin
         ser_o  = tie_i ? 1'h1 : pat[i];
         lclk_o = pol_i;
         #62.5;
         lclk_o = ~pol_i;
         #62.5;
      end
      lclk_o = 1'h0;
      // Released line shows the inverse, not a stale bit
      ser_o  = tie_i ? 1'h1 : ~ser_o;
   endtask
endmodule

// >>> timing_line_tx_port_control_test.sv
// Purpose: Self-checking bench for the transmit port control
// Assumes: Output clock 9 carries the far-end link clock
// Notes:   Static clock levels test the mux, bursts the sampling
`timescale 1ns/1ps
module timing_line_tx_port_control_test;
   logic                clk_i, reset_i, tin, hiz, fs, mfs, e;
   logic                oh_pin, oh_slot, oh_gen, spin, lp, ln, pol_f, tie;
   logic                lclk, ser, ck_o, ck_oe, mp_o, mp_oe, nrz_d, nrz_v;
   logic                psync;
   logic [8:0]          oc_q;
   tltx_pkg::tltx_cfg_t cfg;
   tltx_pkg::tltx_line_t line;
   int                  n_mismatch, cmp_count;
   tltx_far_end far (.pol_i(pol_f), .tie_i(tie), .lclk_o(lclk), .ser_o(ser));
   tltx_port dut (.clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg),
      .output_clocks_i(oc_q | {9{lclk}}), .tx_multipurpose_in_i(tin),
      .tx_serial_data_in_i(ser), .line_hiz_pin_i(hiz), .frame_sync_i(fs),
      .multiframe_sync_i(mfs), .overhead_from_pin_i(oh_pin),
      .overhead_slot_i(oh_slot), .overhead_gen_i(oh_gen),
      .sync_from_pin_i(spin), .line_pos_i(lp), .line_neg_i(ln),
      .tx_clock_out_o(ck_o), .tx_clock_out_oe_o(ck_oe),
      .tx_multipurpose_out_o(mp_o), .tx_multipurpose_out_oe_o(mp_oe),
      .nrz_data_o(nrz_d), .nrz_valid_o(nrz_v), .pin_sync_o(psync),
      .line_o(line));
   initial begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic end_sim();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (5) @(posedge clk_i);
      #1;
   endtask
   task automatic stream(input logic [7:0] pat, input logic [7:0] n_exp);
      int n;
      n = 0;
      fork
         far.burst(pat);
         repeat (110) begin
            @(posedge clk_i);
            #1;
            if (nrz_v === 1'h1) begin
               chk(nrz_d, cfg.transmit_mode_field[1] ? 1'h1 :
                   (oh_slot & ~oh_pin) ? oh_gen : pat[n]);
               n++;
            end
         end
      join
      chk(n[7:0], n_exp);
   endtask
   initial begin
      #200us;
      n_mismatch++;
      end_sim();
   end
   initial begin
      cfg = '0;
      oc_q = '0;
      {tin, hiz, fs, mfs, oh_pin, oh_slot, oh_gen, spin, lp, ln} = '0;
      pol_f = 1'h0;
      tie = 1'h0;
      reset_i = 1'h1;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk_i);
      reset_i <= 1'h0;
      @(posedge clk_i);
      #1;
      chk({nrz_d, ck_oe, mp_oe, line.oe}, 8'h08);
      for (int k = 0; k < 16; k++) begin
         @(posedge clk_i);
         {hiz, cfg.line_driver_on_bit, cfg.transmitter_powerdown_bit} <= k[3:1];
         lp <= k[0];
         ln <= ~k[0];
         settle();
         e = ~k[3] & k[2] & ~k[1];
         chk({line.oe, line.pos, line.neg}, {e, e & k[0], e & ~k[0]});
      end
      @(posedge clk_i);
      oc_q <= 9'h1a5;
      tin <= 1'h1;
      cfg.clock_out_enable_bit <= 1'h1;
      for (int s = 0; s < 16; s++) begin
         @(posedge clk_i);
         cfg.clock_source_select_field <= s[3:0];
         settle();
         e = (s == 0) ? tin : (s < 10 && s != 8) ? oc_q[s-1] : 1'h0;
         chk({ck_oe, ck_o}, {1'h1, e});
      end
      @(posedge clk_i);
      cfg.clock_out_enable_bit <= 1'h0;
      settle();
      chk(ck_oe, 1'h0);
      for (int m = 0; m < 8; m++) begin
         @(posedge clk_i);
         {cfg.multipurpose_out_enable_bit, cfg.multipurpose_out_source_field, fs}
            <= m[2:0];
         mfs <= ~m[0];
         settle();
         chk({mp_oe, mp_o & m[2]}, {m[2], m[2] & (m[1] ^ m[0])});
      end
      @(posedge clk_i);
      oc_q <= '0;
      cfg.clock_source_select_field <= 4'h9;
      spin <= 1'h1;
      settle();
      stream(8'hb4, 8'h08);
      chk(psync, 1'h1);
      @(posedge clk_i);
      pol_f <= 1'h1;
      tin <= 1'h0;
      cfg.clock_polarity_bit <= 1'h1;
      settle();
      stream(8'h4b, 8'h08);
      chk(psync, 1'h0);
      @(posedge clk_i);
      oh_slot <= 1'h1;
      oh_gen <= 1'h1;
      settle();
      stream(8'h00, 8'h08);
      @(posedge clk_i);
      cfg.transmit_mode_field <= 2'h2;
      {tie, tin, oh_gen} <= 3'h6;
      settle();
      stream(8'h00, 8'h08);
      chk(psync, 1'h0);
      @(posedge clk_i);
      {tie, oh_slot} <= 2'h0;
      settle();
      stream(8'h00, 8'h08);
      chk(nrz_d, 1'h1);
      end_sim();
   end
endmodule
